// ---- rtl/pot_pkg.sv ----
/*
  Shared constants and carrier types of the panel output unit: frame
  geometry, byte-select fields, generator set-up and output port bundle.
  Assumes one back-end clock and static configuration while a frame runs.
*/
package pot_pkg;
  // ==========================================================
  // Widths and counts
  localparam int CW = 12;
  localparam int NGEN = 10;
  localparam int NSUB = 12;
  localparam int NPORT = 6;
  localparam int PIXW = 48;
  localparam int FIFO_DEPTH = 32;
  localparam logic [CW-1:0] POS_FIRST = 12'h001;
  // ==========================================================
  // Byte select field positions
  localparam int SEL_ALIGN = 7;
  localparam int SEL_SWAP = 6;
  localparam int SEL_INV = 5;
  localparam int SEL_LSB = 0;
  localparam int SEL_MSB = 2;
  // ==========================================================
  // Byte positions inside a pixel pair word
  localparam int R0_LSB = 40;
  localparam int G0_LSB = 32;
  localparam int B0_LSB = 24;
  localparam int R1_LSB = 16;
  localparam int G1_LSB = 8;
  localparam int B1_LSB = 0;
  // ==========================================================
  // Wait modes
  localparam logic [1:0] WAIT_ONE = 2'h0;
  localparam logic [1:0] WAIT_ROW = 2'h1;
  localparam logic [1:0] WAIT_FREE = 2'h3;

  typedef enum logic [1:0] {
    SRC_BLANK = 2'h0,
    SRC_BORDER = 2'h1,
    SRC_PICTURE = 2'h3
  } pot_src_t;

  typedef struct packed {
    logic line_mode;
    logic start_toggle;
    logic end_toggle;
    logic invert;
    logic [CW-1:0] start_col;
    logic [CW-1:0] start_row;
    logic [CW-1:0] end_col;
    logic [CW-1:0] end_row;
  } pot_gen_t;

  typedef struct packed {
    logic [CW-1:0] blank_len;
    logic [CW-1:0] border_len;
    logic [CW-1:0] picture_len;
    logic [CW-1:0] last_line;
    logic [CW-1:0] act_sx;
    logic [CW-1:0] act_sy;
    logic [CW-1:0] pic_sx;
    logic [CW-1:0] pic_sy;
    logic [CW-1:0] pic_ex;
    logic [CW-1:0] pic_ey;
    logic [CW-1:0] act_ex;
    logic [CW-1:0] act_ey;
    logic [CW-1:0] wait_col;
    logic [1:0] wait_mode;
    logic double_pixel;
    logic [23:0] border_rgb;
    logic [23:0] blank_rgb;
    logic [NPORT-1:0][7:0] byte_select;
    pot_gen_t [NSUB-1:0] gen;
  } pot_cfg_t;

  typedef struct packed {
    logic [NPORT-1:0][7:0] data;
    logic [NGEN-1:0] gen_out;
    logic pclk;
  } pot_port_t;
endpackage : pot_pkg

// ---- rtl/pot_top.sv ----
/*
  Panel output unit: pixel FIFO, frame geometry counters, wait points,
  colour mapping onto six ports and ten programmable signal generators.
  Assumes the pixel source and configuration run on core_clk and that
  configuration is held steady while a frame is emitted.
*/
// Contract
// - Whole frame sized by each row's own line length and the last line number.
// - Each frame starts at row 1, column 1.
// - Blanking, border and picture lines each use their own length.
// - Border pixels border colour, blanking blank colour, gaps border colour.
// - Picture lines halt at wait column until picture data is present.
// - Wait mode 11 free, 01 every picture row, 00 first row only.
// - Dual mode maps six bytes, pixel 0 first; single mode three.
// - Alignment bit moves low six bits to the top.
// - Swap bit reverses the byte's bit order.
// - Inversion bit complements the delivered byte.
// - Three-bit select picks red, green or blue of pixel 0 or 1.
// - Ten generator outputs replace fixed sync and enable pins.
// - Start sets or toggles, end resets or toggles, optional inversion.
// - Frame mode acts at window corners; line mode every line of the window.
// - Zero row value disables that action point.
// - Outputs 0 and 1 combine two independent sub-generators.
// - Column value is offset; change lands after programmed column.
// - Single mode one pixel per clock; dual mode pclk every second.
`timescale 1ns/10ps
`default_nettype none

// ==========================================================
// Pixel FIFO
module pot_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 32
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } pot_fifo_st_t;
  pot_fifo_st_t st_ff, nxt_st;
  logic push, pop;

  assign in_ready = (st_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_ff.cnt != '0);
  assign out_data = st_ff.mem[st_ff.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    nxt_st = st_ff;
    if (push) begin
      nxt_st.mem[st_ff.wr] = in_data;
      nxt_st.wr = (st_ff.wr == AW'(DEPTH-1)) ? '0 : st_ff.wr + 1'b1;
    end
    if (pop) begin
      nxt_st.rd = (st_ff.rd == AW'(DEPTH-1)) ? '0 : st_ff.rd + 1'b1;
    end
    nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule : pot_fifo

// ==========================================================
// Output unit
module pot_top #(
  parameter int FIFO_DEPTH = pot_pkg::FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire pot_pkg::pot_cfg_t cfg,
  input wire logic pix_valid,
  output logic pix_ready,
  input wire logic [pot_pkg::PIXW-1:0] pix_data,
  output pot_pkg::pot_port_t panel
);
  import pot_pkg::*;

  typedef struct packed {
    logic [CW-1:0] col;
    logic [CW-1:0] row;
    logic phase;
    logic [NSUB-1:0] gen_q;
    logic [NPORT-1:0][7:0] data;
    logic pclk;
    pot_src_t src;
  } pot_st_t;

  pot_st_t st_ff, nxt_st;
  logic f_valid, f_ready;
  logic [PIXW-1:0] f_data;
  logic tick, halt, wait_en, pic_row, act_row, pic_pos, act_pos;
  logic [CW-1:0] cur_len;
  logic [PIXW-1:0] px;
  logic [NSUB-1:0] start_hit, end_hit;

  // ==========================================================
  // Helpers
  function automatic logic inside_rng(input logic [CW-1:0] v,
                                      input logic [CW-1:0] lo,
                                      input logic [CW-1:0] hi);
    inside_rng = (v >= lo) && (v <= hi);
  endfunction : inside_rng

  function automatic logic [7:0] map_byte(input logic [7:0] sel,
                                          input logic [PIXW-1:0] p,
                                          input logic dual);
    logic [7:0] b;
    logic [7:0] r;
    b = '0;
    r = '0;
    // Pixel 1 bytes read as zero in single mode: only three exist
    unique casez (sel[SEL_MSB:SEL_LSB])
      3'b11?: b = p[R0_LSB +: 8];
      3'b101: b = p[G0_LSB +: 8];
      3'b100: b = p[B0_LSB +: 8];
      3'b01?: b = dual ? p[R1_LSB +: 8] : 8'h00;
      3'b001: b = dual ? p[G1_LSB +: 8] : 8'h00;
      3'b000: b = dual ? p[B1_LSB +: 8] : 8'h00;
    endcase
    if (sel[SEL_ALIGN]) begin
      b = {b[5:0], 2'h0};
    end
    r = b;
    if (sel[SEL_SWAP]) begin
      for (int i = 0; i < 8; i++) begin
        r[i] = b[7-i];
      end
    end
    if (sel[SEL_INV]) begin
      r = ~r;
    end
    map_byte = r;
  endfunction : map_byte

  // ==========================================================
  // Input buffer
  pot_fifo #(
    .WIDTH(PIXW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(pix_valid),
    .in_ready(pix_ready),
    .in_data(pix_data),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // ==========================================================
  // Geometry decode
  always_comb begin
    pic_row = inside_rng(st_ff.row, cfg.pic_sy, cfg.pic_ey);
    act_row = inside_rng(st_ff.row, cfg.act_sy, cfg.act_ey);
    pic_pos = pic_row && inside_rng(st_ff.col, cfg.pic_sx, cfg.pic_ex);
    act_pos = act_row && inside_rng(st_ff.col, cfg.act_sx, cfg.act_ex);
    if (pic_row) begin
      cur_len = cfg.picture_len;
    end else if (act_row) begin
      cur_len = cfg.border_len;
    end else begin
      cur_len = cfg.blank_len;
    end
    unique case (cfg.wait_mode)
      WAIT_ROW: wait_en = pic_row;
      WAIT_ONE: wait_en = (st_ff.row == cfg.pic_sy);
      default: wait_en = 1'b0;
    endcase
    // Stall in either pixel clock phase while at the wait column without data
    halt = wait_en && (st_ff.col == cfg.wait_col) && !f_valid;
    // Dual mode spends two clocks per pixel pair
    tick = (!cfg.double_pixel || st_ff.phase) && !halt;
    f_ready = tick && pic_pos;
  end

  // ==========================================================
  // Generator action points
  always_comb begin
    for (int g = 0; g < NSUB; g++) begin
      // Zero row disables the point; column match is end of column
      start_hit[g] = tick && (cfg.gen[g].start_row != '0) &&
        (st_ff.col == cfg.gen[g].start_col) &&
        (cfg.gen[g].line_mode ?
          inside_rng(st_ff.row, cfg.gen[g].start_row, cfg.gen[g].end_row) :
          (st_ff.row == cfg.gen[g].start_row));
      end_hit[g] = tick && (cfg.gen[g].end_row != '0) &&
        (st_ff.col == cfg.gen[g].end_col) &&
        (cfg.gen[g].line_mode ?
          inside_rng(st_ff.row, cfg.gen[g].start_row, cfg.gen[g].end_row) :
          (st_ff.row == cfg.gen[g].end_row));
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    nxt_st = st_ff;
    px = '0;
    if (!halt) begin
      nxt_st.phase = cfg.double_pixel ? !st_ff.phase : 1'b1;
      nxt_st.pclk = cfg.double_pixel ? !st_ff.pclk : 1'b1;
    end
    if (tick) begin
      if (st_ff.col >= cur_len) begin
        nxt_st.col = POS_FIRST;
        nxt_st.row = (st_ff.row >= cfg.last_line) ? POS_FIRST :
          st_ff.row + 1'b1;
      end else begin
        nxt_st.col = st_ff.col + 1'b1;
      end
      if (pic_pos && f_valid) begin
        px = f_data;
        nxt_st.src = SRC_PICTURE;
      end else if (act_pos) begin
        // Missing picture data falls back to border colour
        px = {cfg.border_rgb, cfg.border_rgb};
        nxt_st.src = SRC_BORDER;
      end else begin
        px = {cfg.blank_rgb, cfg.blank_rgb};
        nxt_st.src = SRC_BLANK;
      end
      for (int p = 0; p < NPORT; p++) begin
        nxt_st.data[p] = map_byte(cfg.byte_select[p], px, cfg.double_pixel);
      end
      for (int g = 0; g < NSUB; g++) begin
        if (start_hit[g]) begin
          nxt_st.gen_q[g] = cfg.gen[g].start_toggle ? !st_ff.gen_q[g] :
            1'b1;
        end
        if (end_hit[g]) begin
          nxt_st.gen_q[g] = cfg.gen[g].end_toggle ? !nxt_st.gen_q[g] :
            1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '{col: POS_FIRST, row: POS_FIRST, src: SRC_BLANK,
        default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Panel outputs
  always_comb begin
    panel.data = st_ff.data;
    panel.pclk = st_ff.pclk;
    // Sub-generators 0..3 pair up onto outputs 0 and 1
    panel.gen_out[0] = (st_ff.gen_q[0] ^ cfg.gen[0].invert) ^
      (st_ff.gen_q[1] ^ cfg.gen[1].invert);
    panel.gen_out[1] = (st_ff.gen_q[2] ^ cfg.gen[2].invert) ^
      (st_ff.gen_q[3] ^ cfg.gen[3].invert);
    for (int o = 2; o < NGEN; o++) begin
      panel.gen_out[o] = st_ff.gen_q[o+2] ^ cfg.gen[o+2].invert;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  chk_col_wrap: assert property (
    tick && (st_ff.col >= cur_len) |=> st_ff.col == POS_FIRST)
    else $error("column did not wrap to one");
  chk_frame_start: assert property (
    tick && (st_ff.col >= cur_len) && (st_ff.row >= cfg.last_line)
    |=> st_ff.row == POS_FIRST && st_ff.col == POS_FIRST)
    else $error("frame did not restart at row one");
  chk_wait_hold: assert property (
    halt |=> $stable(st_ff.col) && $stable(st_ff.row))
    else $error("counters moved during wait");
  chk_free_run: assert property (
    cfg.wait_mode == WAIT_FREE |-> !halt)
    else $error("free running mode halted");
  chk_border_fill: assert property (
    tick && pic_pos && !f_valid |=> st_ff.src == SRC_BORDER)
    else $error("missing picture not filled with border");
  chk_dual_clock: assert property (
    cfg.double_pixel && !halt ##1 cfg.double_pixel
    |-> st_ff.pclk != $past(st_ff.pclk))
    else $error("dual mode panel clock did not change");
  chk_point_off: assert property (
    cfg.gen[7].start_row == '0 && cfg.gen[7].end_row == '0
    |=> st_ff.gen_q[7] == $past(st_ff.gen_q[7]))
    else $error("disabled generator changed");
  chk_frame_corner: assert property (
    start_hit[4] && !cfg.gen[4].line_mode |-> st_ff.row == cfg.gen[4].start_row)
    else $error("frame mode start off its corner");
endmodule : pot_top

`default_nettype wire

// ---- testbench/pot_panel_model.sv ----
/*
  Panel model: a timing-controller-less panel that tallies each frame.
  Assumes single-pixel mode and a frame marker toggling on output 2.
*/
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Panel model
module pot_panel_model (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire pot_pkg::pot_port_t panel,
  input wire logic [47:0] blank_w,
  input wire logic [47:0] border_w,
  output int frames,
  output logic [6:0][15:0] st
);
  import pot_pkg::*;
  logic [6:0][15:0] cnt;
  logic [6:0] inc;
  logic mark_ff;
  // Tallies: period, outputs 0 1 3 4, border words, picture words
  always_comb begin
    inc = {panel.data !== border_w && panel.data !== blank_w,
           panel.data === border_w, panel.gen_out[4],
           panel.gen_out[3], panel.gen_out[1:0], 1'b1};
  end
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      frames <= 0;
      cnt <= '0;
      st <= '0;
      mark_ff <= 1'b0;
    end else begin
      mark_ff <= panel.gen_out[2];
      for (int i = 0; i < 7; i++) begin
        cnt[i] <= (panel.gen_out[2] != mark_ff) ? 16'(inc[i])
                  : cnt[i] + 16'(inc[i]);
      end
      // A new frame begins: freeze the tallies of the last one
      if (panel.gen_out[2] != mark_ff) begin
        frames <= frames + 1;
        st <= cnt;
      end
    end
  end
endmodule : pot_panel_model
`default_nettype wire

// ---- testbench/pot_top_tb.sv ----
/*
  Self-checking bench of the panel output unit: wait modes, colour
  mapping, frame geometry and generators. Single-pixel mode except a last dual-mode pclk check.
*/
`timescale 1ns/10ps
`default_nettype none
module pot_top_tb;
  import pot_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  pot_cfg_t cfg = '0;
  logic pix_valid = 1'b0;
  logic [PIXW-1:0] pix_data = '0;
  logic pix_ready;
  pot_port_t panel;
  logic [47:0] blank_w;
  logic [47:0] border_w;
  logic [6:0][15:0] st;
  logic chk_on = 1'b0;
  logic refused = 1'b0;
  int frames;
  int f0;
  int err_total = 0;
  int n_compared = 0;
  int feed_n = 0;
  logic [63:0] rng = 64'h24;
  logic [63:0] rng_f = 64'h24;
  logic [47:0] q[$];
  logic [5:0][2:0] codes = {3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};

  always #4 core_clk = ~core_clk;

  pot_top i_pot_top (.core_clk(core_clk), .arst_n(arst_n), .cfg(cfg),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .pix_data(pix_data),
    .panel(panel));
  pot_panel_model i_pot_panel_model (.core_clk(core_clk),
    .arst_n(arst_n), .panel(panel), .blank_w(blank_w),
    .border_w(border_w), .frames(frames), .st(st));

  function automatic logic [63:0] xs(input logic [63:0] x);
    x ^= x << 13;
    x ^= x >> 7;
    x ^= x << 17;
    return x;
  endfunction : xs

  function automatic logic [47:0] map(input logic [47:0] p,
                                      input logic [5:0][7:0] sel);
    logic [47:0] w;
    logic [7:0] b;
    logic [7:0] s;
    for (int k = 0; k < NPORT; k++) begin
      s = sel[k];
      b = p[8 * (s[2] ? (s[1] ? 5 : s[0] ? 4 : 3)
                : (s[1] ? 2 : s[0] ? 1 : 0)) +: 8];
      if (s[SEL_ALIGN]) b = {b[5:0], 2'h0};
      if (s[SEL_SWAP]) b = {<<{b}};
      if (s[SEL_INV]) b = ~b;
      w[8 * k +: 8] = b;
    end
    return w;
  endfunction : map

  function automatic int frame_len();
    int n;
    n = 0;
    for (int r = 1; r <= int'(cfg.last_line); r++) begin
      if (r >= cfg.pic_sy && r <= cfg.pic_ey) n += cfg.picture_len;
      else if (r >= cfg.act_sy && r <= cfg.act_ey) n += cfg.border_len;
      else n += cfg.blank_len;
    end
    return n;
  endfunction : frame_len

  task automatic chk(input string what, input logic [47:0] seen,
                     input logic [47:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Single mode: pixel 1 bytes read as zero
  assign blank_w = map({cfg.blank_rgb, 24'h0}, cfg.byte_select);
  assign border_w = map({cfg.border_rgb, 24'h0}, cfg.byte_select);

  // ==========================================================
  // Pixel source: holds each word until it is taken
  always @(posedge core_clk) begin
    if (arst_n && pix_valid && pix_ready) begin
      q.push_back({pix_data[47:24], 24'h0});
      feed_n--;
    end
    if (pix_valid && !pix_ready) refused = 1'b1;
    if (!pix_valid || pix_ready) begin
      rng_f = xs(rng_f);
      pix_valid <= feed_n > 0;
      pix_data <= rng_f[47:0];
    end
  end

  // Every word that is neither blank nor border is the next pixel
  always @(posedge core_clk) begin
    if (arst_n && chk_on && panel.data !== blank_w
        && panel.data !== border_w) begin
      chk("picture word", panel.data,
          q.size() > 0 ? map(q.pop_front(), cfg.byte_select) : '0);
    end
  end

  initial begin
    #(8 * 8000);
    err_total++;
    $display("watchdog expired");
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial begin
    // Geometry kept legal: starts past column 1, picture inside active
    cfg.blank_len = 12'h00E;
    cfg.border_len = 12'h00D;
    cfg.picture_len = 12'h00C;
    cfg.last_line = 12'h008;
    cfg.act_sx = 12'h003;
    cfg.act_sy = 12'h002;
    cfg.act_ex = 12'h00A;
    cfg.act_ey = 12'h007;
    cfg.pic_sx = 12'h004;
    cfg.pic_sy = 12'h003;
    cfg.pic_ex = 12'h009;
    cfg.pic_ey = 12'h006;
    cfg.wait_col = 12'h002;
    // Generators: no column offset zero; generator 0 starts on the wait column
    cfg.gen[0] = {4'h8, 48'h002_001_006_008};
    cfg.gen[1] = {4'h8, 48'h004_001_008_008};
    cfg.gen[2].invert = 1'b1;
    cfg.gen[4] = {4'h4, 48'h001_001_000_000};
    cfg.gen[5] = {4'h8, 48'h001_001_005_008};
    cfg.gen[6] = {4'h8, 48'h003_003_009_006};
    foreach (codes[m]) begin
      if (m > 2) continue;
      @(posedge core_clk);
      arst_n <= 1'b0;
      chk_on <= 1'b0;
      feed_n <= 0;
      cfg.wait_mode <= m == 0 ? WAIT_FREE : m == 1 ? WAIT_ROW : WAIT_ONE;
      rng = xs(rng);
      cfg.border_rgb <= rng[31:8];
      cfg.blank_rgb <= rng[55:32];
      for (int k = 0; k < NPORT; k++) begin
        rng = xs(rng);
        cfg.byte_select[k] <= {rng[7:5], 2'h0,
                               codes[k] ^ {2'h0, codes[k][1] & rng[9]}};
      end
      repeat (2) @(posedge core_clk);
      chk("gens in reset", panel.gen_out, 10'h002);
      q.delete();
      refused = 1'b0;
      arst_n <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk_on <= 1'b1;
      // No data: waiting modes halt in the first picture row
      repeat (250) @(posedge core_clk);
      chk("frames idle", frames, m == 0 ? 3 : 1);
      // One row of data: both waiting modes halt again, free run does not
      feed_n <= 6;
      repeat (250) @(posedge core_clk);
      chk("frames one row", frames > 2, m == 0);
      feed_n <= 100000;
      f0 = frames;
      for (int i = 0; i < 1000 && frames < f0 + 3; i++) begin
        @(posedge core_clk);
      end
      chk("frame length", st[0], frame_len());
      chk("out0 high", st[1], 32);
      chk("out1 high", st[2], frame_len());
      chk("out3 high", st[3], 32);
      chk("out4 high", st[4], 24);
      chk("border words", st[5], 24);
      chk("picture words", st[6], 24);
      chk("fifo refused", refused, 1'b1);
      chk("pclk", panel.pclk, 1'b1);
      chk("idle gens", panel.gen_out[9:5], 5'h00);
      feed_n <= 0;
      $display("wait mode test %0d done", m);
    end
    // Dual mode: the panel clock toggles on every running core clock
    @(posedge core_clk);
    arst_n <= 1'b0;
    chk_on <= 1'b0;
    cfg.double_pixel <= 1'b1;
    cfg.wait_mode <= WAIT_FREE;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    f0 = int'(panel.pclk);
    @(posedge core_clk);
    chk("dual pclk", panel.pclk, !f0[0]);
    @(posedge core_clk);
    chk("dual pclk back", panel.pclk, f0[0]);
    $display("dual pixel test done");
    end_of_test();
  end
endmodule : pot_top_tb
`default_nettype wire
